// *** fsap_top.sv ***
// Functional notes
// (R1) level 2 disables debug, RAM boot and loader boot; debug accesses refused.
// (R2) system memory is read-only; writes and erases always refused.
// (R3) option bytes change only via register program start; direct writes refused.
// (R4) regression from level 1 to 0 erases the whole main flash first.
// (R5) each OTP row programs once; later writes to it are refused.
// (R6) regression 1 to 0 or 0.5 clears all backup registers.
// (R7) regression 1 to 0 or 0.5 erases every SRAM.
// (R8) at level 0.5 debug access follows target and requester security.
// (R9) ECC corrects single, detects double errors, records failing address.
// (R10) with security extension on, all flash pages secure after reset.
// (R11) watermark secure flash area refuses any non-secure access.
// (R12) activated hidden area refuses read, write, fetch until reset.
// (R13) per-page flash security attribute, software writable at run time.
// (R14) per-page flash privilege attribute refuses unprivileged access.
// (R15) SRAMs secure after reset; 512-byte blocks marked secure by software.
// (R16) per-block SRAM privilege attribute refuses unprivileged access.
// (R17) flash has 128 pages of 8 Kbytes; page is the attribute unit.
// (R18) level 0.5 only selectable with the security extension enabled.
// (R19) refused access ends with error response and leaves memory unchanged.
`timescale 1ns/1ps
`default_nettype none
module fsap_top import fsap_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output var logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output var logic s_axi_wready,
  output var logic [1:0] s_axi_bresp,
  output var logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output var logic s_axi_arready,
  output var logic [31:0] s_axi_rdata,
  output var logic [1:0] s_axi_rresp,
  output var logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire fsap_req_t acc_req,
  output var fsap_rsp_t acc_rsp,
  input wire logic ecc_single,
  input wire logic ecc_double,
  input wire logic [31:0] ecc_addr_in,
  input wire logic flash_erase_done,
  output var logic erase_flash,
  output var logic erase_sram,
  output var logic clear_backup,
  output var logic debug_enable,
  output var logic irq
);
  // --------------------------------------------------
  // helpers
  // --------------------------------------------------
  function automatic logic fsap_mapped(input logic [7:0] a);
    fsap_mapped = (a[1:0] == 2'h0) && ((a <= A_OTP) ||
      ((a[7:4] >= GRP_BASE) && (a[7:4] <= GRP_LAST)));
  endfunction : fsap_mapped

  function automatic logic fsap_in_span(input logic [PG_W:0] p, input logic [PG_W:0] lo,
                                        input logic [PG_W:0] hi);
    fsap_in_span = (p >= lo) && (p < hi);
  endfunction : fsap_in_span

  function automatic logic fsap_attr(input fsap_state_t s, input logic [2:0] g,
                                     input logic [PG_W-1:0] i);
    fsap_attr = s.attr[g][i[6:5]][i[4:0]];
  endfunction : fsap_attr

  function automatic logic [31:0] fsap_merge(input logic [31:0] old, input logic [31:0] d,
                                             input logic [3:0] be);
    fsap_merge = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        fsap_merge[b*8 +: 8] = d[b*8 +: 8];
      end
    end
  endfunction : fsap_merge

  fsap_state_t st_reg, st_next;
  logic [PG_W-1:0] pg, blk;
  logic [ROW_W-1:0] row;
  logic in_wm, in_hide, deny, wr_go, prog_req, opt_ok, regress, apply;
  logic [1:0] new_lvl;
  logic [2:0] wg, rg;

  assign pg = acc_req.offset[PAGE_LSB +: PG_W];
  assign blk = acc_req.offset[BLK_LSB +: PG_W];
  assign row = acc_req.offset[ROW_LSB +: ROW_W];
  assign in_wm = fsap_in_span({1'b0, pg}, {1'b0, st_reg.wm_s},
    {1'b0, st_reg.wm_e} + 8'h01);
  assign in_hide = fsap_in_span({1'b0, pg}, {1'b0, st_reg.wm_s},
    {1'b0, st_reg.wm_s} + {1'b0, st_reg.hide_len});
  assign wr_go = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;
  assign prog_req = wr_go && (st_reg.awaddr == A_CTRL) && st_reg.wstrb[0] &&
    st_reg.wdata[CTRL_PROG];
  assign new_lvl = st_reg.pend[P_LVL +: 2];
  // level 2 cannot be left: the regression key is not held here
  assign opt_ok = (st_reg.level != LVL_2) && (st_reg.fsm == FS_IDLE) &&
    !((new_lvl == LVL_05) && !st_reg.pend[P_TZ]); // (R18)
  assign regress = (st_reg.level == LVL_1) && ((new_lvl == LVL_0) || (new_lvl == LVL_05));
  assign wg = 3'(st_reg.awaddr[7:4] - GRP_BASE);
  assign rg = 3'(s_axi_araddr[7:4] - GRP_BASE);

  // --------------------------------------------------
  // access check
  // --------------------------------------------------
  always_comb begin
    deny = 1'b0;
    if (acc_req.debug && ((st_reg.level == LVL_2) || ((st_reg.level == LVL_1) &&
        (acc_req.region inside {RG_MAIN, RG_BKP, RG_PSRAM})))) begin
      deny = 1'b1; // (R1)
    end
    case (acc_req.region)
      RG_MAIN: begin
        if (st_reg.sec_ext && !acc_req.secure && (fsap_attr(st_reg, G_FSEC, pg) || in_wm)) begin
          deny = 1'b1; // (R8) (R11) (R13) (R17)
        end
        if (st_reg.sec_ext && st_reg.hide_act && in_hide) begin
          deny = 1'b1; // (R12)
        end
        if (!acc_req.priv && fsap_attr(st_reg, G_FPRIV, pg)) begin
          deny = 1'b1; // (R14)
        end
        if ((st_reg.fsm == FS_ERASE) && (acc_req.kind != K_READ)) begin
          deny = 1'b1;
        end
      end
      RG_SYS: begin
        if (acc_req.kind inside {K_WRITE, K_ERASE}) begin
          deny = 1'b1; // (R2)
        end
      end
      RG_OPT: begin
        if (acc_req.kind != K_READ) begin
          deny = 1'b1; // (R3)
        end
      end
      RG_OTP: begin
        if ((acc_req.kind == K_ERASE) ||
            ((acc_req.kind == K_WRITE) && st_reg.otp_lock[row])) begin
          deny = 1'b1; // (R5)
        end
      end
      RG_BKP: begin
        // backup registers count as secure targets for debug accesses while the extension is on
        if (acc_req.debug && st_reg.sec_ext && !acc_req.secure) begin
          deny = 1'b1; // (R8)
        end
      end
      RG_SRAM1: begin
        if ((st_reg.sec_ext && !acc_req.secure && fsap_attr(st_reg, G_S1SEC, blk)) ||
            (!acc_req.priv && fsap_attr(st_reg, G_S1PRIV, blk))) begin
          deny = 1'b1; // (R15) (R16)
        end
      end
      RG_PSRAM: begin
        if ((st_reg.sec_ext && !acc_req.secure && fsap_attr(st_reg, G_S2SEC, blk)) ||
            (!acc_req.priv && fsap_attr(st_reg, G_S2PRIV, blk))) begin
          deny = 1'b1; // (R8) (R15) (R16)
        end
      end
      default: deny = 1'b1;
    endcase
  end

  // --------------------------------------------------
  // next state
  // --------------------------------------------------
  always_comb begin
    st_next = st_reg;
    apply = 1'b0;
    st_next.rsp = '0;
    st_next.erase_flash = 1'b0;
    st_next.erase_sram = 1'b0;
    st_next.clear_bkp = 1'b0;
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (wr_go) begin
      st_next.aw_held = 1'b0;
      st_next.w_held = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = fsap_mapped(st_reg.awaddr) ? RESP_OK : RESP_SLVERR;
      case (st_reg.awaddr)
        A_CTRL: begin
          if (st_reg.wstrb[0] && st_reg.wdata[CTRL_HIDE]) begin
            st_next.hide_act = 1'b1; // (R12)
          end
        end
        A_PEND: st_next.pend = fsap_merge(st_reg.pend, st_reg.wdata, st_reg.wstrb);
        A_MASK: st_next.mask = st_reg.wstrb[0] ? st_reg.wdata[STAT_W-1:0] : st_reg.mask;
        default: begin
          if (fsap_mapped(st_reg.awaddr) && (st_reg.awaddr[7:4] >= GRP_BASE)) begin
            st_next.attr[wg][st_reg.awaddr[3:2]] = fsap_merge(
              st_reg.attr[wg][st_reg.awaddr[3:2]], st_reg.wdata, st_reg.wstrb); // (R13) (R14) (R15) (R16)
          end
        end
      endcase
    end
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.aw_held = 1'b1;
      st_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.w_held = 1'b1;
      st_next.wdata = s_axi_wdata;
      st_next.wstrb = s_axi_wstrb;
    end
    st_next.awready = !st_next.aw_held && !st_next.bvalid;
    st_next.wready = !st_next.w_held && !st_next.bvalid;
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
      st_next.arready = 1'b1;
    end
    // read-to-clear runs before the event sets below, so a same-cycle event survives
    if (s_axi_arvalid && st_reg.arready) begin
      st_next.arready = 1'b0;
      st_next.rvalid = 1'b1;
      st_next.rresp = fsap_mapped(s_axi_araddr) ? RESP_OK : RESP_SLVERR;
      st_next.rdata = '0;
      case (s_axi_araddr)
        A_CTRL: st_next.rdata[CTRL_HIDE] = st_reg.hide_act;
        A_PEND: st_next.rdata = st_reg.pend;
        A_CUR: begin
          st_next.rdata[P_LVL +: 2] = st_reg.level;
          st_next.rdata[P_TZ] = st_reg.sec_ext;
          st_next.rdata[C_HDPACT] = st_reg.hide_act;
          st_next.rdata[C_ERASE] = (st_reg.fsm == FS_ERASE);
          st_next.rdata[P_WMS +: PG_W] = st_reg.wm_s;
          st_next.rdata[P_WME +: PG_W] = st_reg.wm_e;
          st_next.rdata[P_HIDE +: PG_W] = st_reg.hide_len;
        end
        A_STAT: begin
          st_next.rdata[STAT_W-1:0] = st_reg.status;
          st_next.status = '0;
        end
        A_MASK: st_next.rdata[STAT_W-1:0] = st_reg.mask;
        A_ECC: st_next.rdata = st_reg.ecc_addr;
        A_OTP: st_next.rdata = st_reg.otp_lock;
        default: begin
          if (fsap_mapped(s_axi_araddr) && (s_axi_araddr[7:4] >= GRP_BASE)) begin
            st_next.rdata = st_reg.attr[rg][s_axi_araddr[3:2]];
          end
        end
      endcase
    end
    // option programming: only path by which level and areas change
    if (prog_req) begin
      if (!opt_ok) begin
        st_next.status[STAT_OPTERR] = 1'b1; // (R18)
      end else begin
        if (regress) begin
          st_next.erase_sram = 1'b1; // (R7)
          st_next.clear_bkp = 1'b1; // (R6)
        end
        if (regress && (new_lvl == LVL_0)) begin
          st_next.erase_flash = 1'b1; // (R4)
          st_next.fsm = FS_ERASE;
        end else begin
          apply = 1'b1; // (R3)
        end
      end
    end
    case (st_reg.fsm)
      FS_IDLE: ;
      FS_ERASE: begin
        if (flash_erase_done) begin
          apply = 1'b1; // (R4)
          st_next.fsm = FS_IDLE;
        end
      end
      default: st_next.fsm = FS_IDLE;
    endcase
    if (apply) begin
      st_next.level = new_lvl;
      st_next.sec_ext = st_reg.pend[P_TZ];
      st_next.wm_s = st_reg.pend[P_WMS +: PG_W];
      st_next.wm_e = st_reg.pend[P_WME +: PG_W];
      st_next.hide_len = st_reg.pend[P_HIDE +: PG_W];
      st_next.status[STAT_OPTDONE] = 1'b1;
    end
    if (acc_req.valid) begin
      st_next.rsp.done = 1'b1;
      st_next.rsp.err = deny; // (R19)
      if (deny) begin
        st_next.status[STAT_DENY] = 1'b1;
      end else if ((acc_req.region == RG_OTP) && (acc_req.kind == K_WRITE)) begin
        st_next.otp_lock[row] = 1'b1; // (R5)
      end
    end
    if (ecc_single) begin
      st_next.status[STAT_ECC1] = 1'b1; // (R9)
    end
    if (ecc_double) begin
      st_next.status[STAT_ECC2] = 1'b1; // (R9)
    end
    if (ecc_single || ecc_double) begin
      st_next.ecc_addr = ecc_addr_in; // (R9)
    end
    st_next.irq = |(st_next.status & st_next.mask);
    st_next.dbg_en = (st_next.level != LVL_2); // (R1)
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.fsm <= FS_IDLE;
      st_reg.awready <= 1'b1;
      st_reg.wready <= 1'b1;
      st_reg.arready <= 1'b1;
      st_reg.level <= LEVEL_RST;
      st_reg.sec_ext <= SEC_EXT_RST;
      st_reg.dbg_en <= (LEVEL_RST != LVL_2);
      st_reg.attr[G_FSEC] <= {128{SEC_EXT_RST}}; // (R10)
      st_reg.attr[G_S1SEC] <= {128{SEC_EXT_RST}}; // (R15)
      st_reg.attr[G_S2SEC] <= {128{SEC_EXT_RST}}; // (R15)
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign acc_rsp = st_reg.rsp;
  assign erase_flash = st_reg.erase_flash;
  assign erase_sram = st_reg.erase_sram;
  assign clear_backup = st_reg.clear_bkp;
  assign debug_enable = st_reg.dbg_en;
  assign irq = st_reg.irq;

  // --------------------------------------------------
  // checks
  // --------------------------------------------------
  level2_debug_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R1)
    acc_req.valid && acc_req.debug && (st_reg.level == LVL_2) |=> acc_rsp.err && !debug_enable)
    else $error("debug access granted at level 2");
  sysmem_ro_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R2)
    acc_req.valid && (acc_req.region == RG_SYS) && (acc_req.kind != K_READ) &&
    (acc_req.kind != K_FETCH) |=> acc_rsp.done && acc_rsp.err)
    else $error("system memory write not refused");
  option_direct_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R3)
    acc_req.valid && (acc_req.region == RG_OPT) && (acc_req.kind == K_WRITE) |=> acc_rsp.err)
    else $error("direct option write not refused");
  flash_erase_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R4)
    prog_req && opt_ok && regress && (new_lvl == LVL_0) |=>
    erase_flash && (st_reg.level == LVL_1) ##1 !erase_flash)
    else $error("regression did not erase flash first");
  otp_once_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R5)
    acc_req.valid && (acc_req.region == RG_OTP) && (acc_req.kind == K_WRITE) &&
    st_reg.otp_lock[row] |=> acc_rsp.err && !$changed(st_reg.otp_lock))
    else $error("otp row written twice");
  wipe_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R6) (R7)
    prog_req && opt_ok && regress |=> clear_backup && erase_sram)
    else $error("regression without backup and sram wipe");
  ecc_addr_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R9)
    ecc_double |=> (st_reg.ecc_addr == $past(ecc_addr_in)) && st_reg.status[STAT_ECC2])
    else $error("ecc failure address not recorded");
  hidden_area_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R12)
    acc_req.valid && (acc_req.region == RG_MAIN) && st_reg.sec_ext && st_reg.hide_act &&
    in_hide |=> acc_rsp.err)
    else $error("hidden area access granted");
  priv_page_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R14)
    acc_req.valid && (acc_req.region == RG_MAIN) && !acc_req.priv &&
    fsap_attr(st_reg, G_FPRIV, pg) |=> acc_rsp.err)
    else $error("unprivileged page access granted");
  half_level_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R18)
    prog_req && (new_lvl == LVL_05) && !st_reg.pend[P_TZ] |=>
    $stable(st_reg.level) && st_reg.status[STAT_OPTERR])
    else $error("level 0.5 taken without security extension");
  refuse_resp_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R19)
    acc_rsp.err |-> acc_rsp.done && st_reg.status[STAT_DENY])
    else $error("refusal without error completion");
endmodule : fsap_top
`default_nettype wire

// *** fsap_pkg.sv ***
`default_nettype none
package fsap_pkg;
  // --------------------------------------------------
  // protection levels and option defaults
  // --------------------------------------------------
  localparam logic [1:0] LVL_0 = 2'h0;
  localparam logic [1:0] LVL_05 = 2'h1;
  localparam logic [1:0] LVL_1 = 2'h2;
  localparam logic [1:0] LVL_2 = 2'h3;
  localparam logic [1:0] LEVEL_RST = LVL_0;
  localparam logic SEC_EXT_RST = 1'b1;
  // --------------------------------------------------
  // memory geometry
  // --------------------------------------------------
  localparam int OFS_W = 20;
  localparam int PG_W = 7;
  localparam int ROW_W = 5;
  localparam int PAGE_LSB = 13;
  localparam int BLK_LSB = 9;
  localparam int ROW_LSB = 4;
  localparam int ATTR_GRPS = 6;
  localparam logic [2:0] G_FSEC = 3'h0;
  localparam logic [2:0] G_FPRIV = 3'h1;
  localparam logic [2:0] G_S1SEC = 3'h2;
  localparam logic [2:0] G_S1PRIV = 3'h3;
  localparam logic [2:0] G_S2SEC = 3'h4;
  localparam logic [2:0] G_S2PRIV = 3'h5;
  // --------------------------------------------------
  // register map and fields
  // --------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_PEND = 8'h04;
  localparam logic [7:0] A_CUR = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0c;
  localparam logic [7:0] A_MASK = 8'h10;
  localparam logic [7:0] A_ECC = 8'h14;
  localparam logic [7:0] A_OTP = 8'h18;
  localparam logic [3:0] GRP_BASE = 4'h2;
  localparam logic [3:0] GRP_LAST = 4'h7;
  localparam int CTRL_PROG = 0;
  localparam int CTRL_HIDE = 1;
  localparam int P_LVL = 0;
  localparam int P_TZ = 2;
  localparam int P_WMS = 8;
  localparam int P_WME = 16;
  localparam int P_HIDE = 24;
  localparam int C_HDPACT = 3;
  localparam int C_ERASE = 4;
  localparam int STAT_W = 5;
  localparam int STAT_ECC1 = 0;
  localparam int STAT_ECC2 = 1;
  localparam int STAT_DENY = 2;
  localparam int STAT_OPTERR = 3;
  localparam int STAT_OPTDONE = 4;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // --------------------------------------------------
  // types
  // --------------------------------------------------
  typedef enum logic [2:0] {RG_MAIN, RG_SYS, RG_OPT, RG_OTP, RG_BKP, RG_SRAM1,
    RG_PSRAM} fsap_region_t;
  typedef enum logic [1:0] {K_READ, K_WRITE, K_ERASE, K_FETCH} fsap_kind_t;
  typedef enum logic {FS_IDLE, FS_ERASE} fsap_fsm_t;
  typedef struct packed {
    logic valid;
    fsap_region_t region;
    fsap_kind_t kind;
    logic [OFS_W-1:0] offset;
    logic secure;
    logic priv;
    logic debug;
  } fsap_req_t;
  typedef struct packed {
    logic done;
    logic err;
  } fsap_rsp_t;
  typedef struct packed {
    fsap_fsm_t fsm;
    logic awready, wready, bvalid, arready, rvalid, aw_held, w_held;
    logic [1:0] bresp, rresp;
    logic [7:0] awaddr;
    logic [31:0] wdata, rdata, pend, ecc_addr, otp_lock;
    logic [3:0] wstrb;
    logic [1:0] level;
    logic sec_ext, hide_act;
    logic [PG_W-1:0] wm_s, wm_e, hide_len;
    logic [STAT_W-1:0] status, mask;
    logic [ATTR_GRPS-1:0][3:0][31:0] attr;
    fsap_rsp_t rsp;
    logic erase_flash, erase_sram, clear_bkp, irq, dbg_en;
  } fsap_state_t;
endpackage : fsap_pkg
`default_nettype wire

// *** fsap_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module fsap_master_model import fsap_pkg::*; #(
  parameter int ERASE_CYC = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic go,
  input wire fsap_req_t cmd,
  output var fsap_req_t acc_req,
  input wire logic erase_flash,
  output var logic flash_erase_done
);
  int cnt;
  always @(posedge aclk) begin
    if (!aresetn) begin
      acc_req <= '0;
      cnt <= 0;
      flash_erase_done <= 1'h0;
    end else begin
      // valid is held low while idle; the other fields keep toggling so only valid marks a request
      acc_req <= go ? cmd : {1'h0, ~acc_req[$bits(fsap_req_t)-2:0]};
      flash_erase_done <= (cnt == 1);
      if (erase_flash) begin
        cnt <= ERASE_CYC;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule : fsap_master_model
`default_nettype wire

// *** fsap_top_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module fsap_top_bench import fsap_pkg::*;;
  localparam int ERASE_CYC = 20;
  logic aclk = 1'h0, aresetn = 1'h0, go = 1'h0, ecc_s = 1'h0, ecc_d = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, ecc_addr = 32'h0, r;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, ef, es, cb, dbg_en, irq, fdone;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  fsap_req_t cmd = '0, req;
  fsap_rsp_t rsp;
  logic [33:0] exp_q[$];
  logic exp_a[$];
  int fail_count = 0, n_compared = 0, cyc = 0, n_ef = 0, n_es = 0, n_cb = 0;
  always #25 aclk = ~aclk;
  fsap_top i_fsap_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .acc_req(req), .acc_rsp(rsp), .ecc_single(ecc_s),
    .ecc_double(ecc_d), .ecc_addr_in(ecc_addr), .flash_erase_done(fdone),
    .erase_flash(ef), .erase_sram(es), .clear_backup(cb), .debug_enable(dbg_en),
    .irq(irq));
  fsap_master_model #(.ERASE_CYC(ERASE_CYC)) i_fsap_master_model (.aclk(aclk),
    .aresetn(aresetn), .go(go), .cmd(cmd), .acc_req(req), .erase_flash(ef),
    .flash_erase_done(fdone));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = RESP_OK);
    logic aw, w;
    aw = 1'h0;
    w = 1'h0;
    exp_q.push_back({e, 32'h0});
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (awready && !aw) begin
        aw = 1'h1;
        awvalid <= 1'h0;
      end
      if (wready && !w) begin
        w = 1'h1;
        wvalid <= 1'h0;
      end
    end
    while (!bvalid) @(posedge aclk);
    bready <= 1'h0;
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = RESP_OK);
    exp_q.push_back({e, d});
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'h0;
    while (!rvalid) @(posedge aclk);
    rready <= 1'h0;
    @(posedge aclk);
  endtask : rd
  // spd: secure, privileged, debug
  task automatic acc(input fsap_region_t g, input fsap_kind_t k, input logic [19:0] o,
      input logic [2:0] spd, input logic e);
    exp_a.push_back(e);
    cmd <= '{1'h1, g, k, o, spd[2], spd[1], spd[0]};
    go <= 1'h1;
    @(posedge aclk);
    go <= 1'h0;
    repeat (3) @(posedge aclk);
  endtask : acc
  task automatic prog(input logic [31:0] p);
    wr(A_PEND, p);
    wr(A_CTRL, 32'h1);
  endtask : prog
  // ----------------------------------------
  // result watcher and timeout
  // ----------------------------------------
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    n_ef <= n_ef + int'(ef);
    n_es <= n_es + int'(es);
    n_cb <= n_cb + int'(cb);
    if (bvalid && bready) chk("bresp", exp_q.pop_front(), {bresp, 32'h0});
    if (rvalid && rready) chk("rdata", exp_q.pop_front(), {rresp, rdata});
    if (rsp.done === 1'h1) chk("acc_err", {33'h0, exp_a.pop_front()}, {33'h0, rsp.err});
    // generous: the sequence needs well under a thousand cycles
    if (cyc == 6000) begin
      fail_count++;
      end_sim();
    end
  end
  initial begin
    void'($urandom(32'he03b));
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(A_CUR, 32'h4);
    rd(8'h20, 32'hffffffff);
    rd(8'h2c, 32'hffffffff);
    rd(8'h40, 32'hffffffff);
    rd(8'h70, 32'h0);
    rd(8'h1c, 32'h0, RESP_SLVERR);
    wr(8'h1c, 32'h1, RESP_SLVERR);
    r = $urandom();
    wr(8'h20, r);
    rd(8'h20, r);
    for (int p = 4; p < 8; p++) acc(RG_MAIN, K_READ, 20'(p << PAGE_LSB), 3'h2, r[p]);
    acc(RG_SYS, K_WRITE, 20'h0, 3'h6, 1'h1);
    acc(RG_SYS, K_ERASE, 20'h0, 3'h6, 1'h1);
    acc(RG_SYS, K_READ, 20'h0, 3'h6, 1'h0);
    acc(RG_OPT, K_WRITE, 20'h0, 3'h6, 1'h1);
    wr(8'h30, 32'h1);
    acc(RG_MAIN, K_READ, 20'h0, 3'h4, 1'h1);
    acc(RG_MAIN, K_FETCH, 20'h0, 3'h6, 1'h0);
    acc(RG_SRAM1, K_READ, 20'h0, 3'h2, 1'h1);
    wr(8'h50, 32'h2);
    acc(RG_SRAM1, K_WRITE, 20'h200, 3'h4, 1'h1);
    acc(RG_SRAM1, K_WRITE, 20'h0, 3'h4, 1'h0);
    acc(RG_OTP, K_WRITE, 20'h30, 3'h6, 1'h0);
    acc(RG_OTP, K_WRITE, 20'h30, 3'h6, 1'h1);
    rd(A_OTP, 32'h8);
    r = $urandom();
    ecc_addr <= r;
    ecc_s <= 1'h1;
    @(posedge aclk);
    ecc_s <= 1'h0;
    ecc_d <= 1'h1;
    @(posedge aclk);
    ecc_d <= 1'h0;
    rd(A_ECC, r);
    wr(A_MASK, 32'h5);
    repeat (2) @(posedge aclk);
    chk("irq", 34'h1, {33'h0, irq});
    rd(A_STAT, 32'h7);
    repeat (2) @(posedge aclk);
    chk("irq", 34'h0, {33'h0, irq});
    prog(32'h6);
    rd(A_CUR, 32'h6);
    acc(RG_MAIN, K_READ, 20'h0, 3'h7, 1'h1);
    prog(32'h4);
    repeat (ERASE_CYC + 6) @(posedge aclk);
    rd(A_CUR, 32'h4);
    chk("erase_counts", 34'h111, {22'h0, 4'(n_ef), 4'(n_es), 4'(n_cb)});
    prog(32'h1);
    rd(A_CUR, 32'h4);
    rd(A_STAT, 32'h1c);
    prog(32'h01050205);
    rd(A_CUR, 32'h01050205);
    acc(RG_PSRAM, K_READ, 20'h0, 3'h3, 1'h1);
    acc(RG_PSRAM, K_WRITE, 20'h0, 3'h7, 1'h0);
    wr(8'h20, 32'h0);
    acc(RG_MAIN, K_READ, 20'h6000, 3'h2, 1'h1);
    acc(RG_MAIN, K_READ, 20'hc000, 3'h2, 1'h0);
    wr(A_CTRL, 32'h2);
    acc(RG_MAIN, K_FETCH, 20'h4000, 3'h6, 1'h1);
    acc(RG_MAIN, K_FETCH, 20'h6000, 3'h6, 1'h0);
    prog(32'h7);
    repeat (2) @(posedge aclk);
    chk("debug_enable", 34'h0, {33'h0, dbg_en});
    acc(RG_SRAM1, K_READ, 20'h0, 3'h7, 1'h1);
    prog(32'h4);
    rd(A_CUR, 32'hf);
    chk("leftover", 34'h0, 34'(exp_q.size() + exp_a.size()));
    end_sim();
  end
endmodule : fsap_top_bench
`default_nettype wire
